// >>> logic/dwp_top.v
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// - Independent watchdog counts down a twelve-bit value from its reload value.
// - Independent watchdog prescaler offers seven selectable division factors.
// - Independent watchdog is clocked from the dedicated low-speed oscillator.
// - Independent watchdog keeps counting in Stop and Standby states.
// - Expiry resets the system, or it runs as a free timer.
// - Start is by software key or by hardware option byte.
// - Independent watchdog counter can be frozen while the core is halted.
// - Window watchdog is a seven-bit down counter, may run free.
// - Window watchdog can reset the entire system.
// - Window watchdog runs from the main system clock.
// - Window watchdog raises an early warning interrupt before reset.
// - Window watchdog counter can be frozen while the core is halted.
// - Independent watchdog reset acts as a wake-up source from Standby.
`include "dwp_defines.vh"
module dwp_top #(
	parameter WIN_DIV = `DWP_WIN_DIV
) (
	input  wire        CLK,
	input  wire        SYS_RST,
	input  wire        LOW_SPEED_INTERNAL_OSC,
	input  wire        OPT_HW_START,
	input  wire        CORE_HALTED,
	input  wire        LOW_POWER,
	input  wire [7:0]  ADDR,
	input  wire [31:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [31:0] RDATA,
	output wire        IRQ,
	output reg         SYS_RESET_REQ,
	output reg         WAKEUP_REQ
);
	reg  [15:0] key_q;
	reg  [2:0]  pre_q;
	reg  [11:0] rld_q;
	reg  [11:0] ind_cnt_q;
	reg         ind_run_q;
	reg         ind_rst_en_q;
	reg         strap_done_q;
	reg  [6:0]  win_cnt_q;
	reg  [6:0]  win_win_q;
	reg         win_en_q;
	reg         win_rst_en_q;
	reg  [2:0]  stat_q;
	reg  [2:0]  mask_q;
	reg  [1:0]  dbg_q;
	reg         osc_prev_q;
	reg  [31:0] win_div_q;
	wire        osc_s;
	wire        osc_edge;
	wire        ind_tick;
	wire        win_tick;
	wire        ind_expire;
	wire        win_early;
	wire        win_fail;
	wire        wr_key;
	wire        wr_win;
	wire [2:0]  ev;
	wire        sel_rld_ok;

	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// The low-speed oscillator is a foreign clock, sampled as a pin.
	dwp_sync3 u_osc_sync (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.d       (LOW_SPEED_INTERNAL_OSC),
		.q       (osc_s)
	);

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			osc_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_s;
		end
	end

	// Counting follows oscillator edges only; LOW_POWER is not consulted.
	assign osc_edge = osc_s && !osc_prev_q && !(dbg_q[0] && CORE_HALTED);

	dwp_prescaler u_pre (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.en      (osc_edge && ind_run_q),
		.clr     (!ind_run_q),
		.sel     (pre_q),
		.tick    (ind_tick)
	);

	assign wr_key     = WR && hit(ADDR, `DWP_OFF_IND_KEY);
	assign wr_win     = WR && hit(ADDR, `DWP_OFF_WIN_CTRL);
	assign ind_expire = ind_tick && (ind_cnt_q == 12'h000);
	assign sel_rld_ok = wr_key && (WDATA[15:0] == `DWP_KEY_RELOAD);

	// Window counter prescale from the main clock.
	assign win_tick = win_en_q && !(dbg_q[1] && CORE_HALTED) && (win_div_q == WIN_DIV - 1);
	assign win_early = win_tick && (win_cnt_q == `DWP_WIN_EWI_VAL);
	// Fails on a tick with bit 6 already clear, or on a reload while enabled and above the window, except in the cycle of the early-warning tick.
	assign win_fail  = (win_tick && (win_cnt_q == `DWP_WIN_EWI_VAL))
		? 1'b0
		: ((win_tick && !win_cnt_q[`DWP_WIN_TRIG_BIT])
		|| (wr_win && win_en_q && (win_cnt_q > win_win_q)));

	assign ev  = {win_fail, win_early, ind_expire};
	assign IRQ = |(stat_q & mask_q);

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			win_div_q <= 32'h00000000;
		end else if (!win_en_q || win_tick) begin
			win_div_q <= 32'h00000000;
		end else if (!(dbg_q[1] && CORE_HALTED)) begin
			win_div_q <= win_div_q + 32'h00000001;
		end
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			key_q        <= 16'h0000;
			pre_q        <= `DWP_IND_PRE_RST;
			rld_q        <= `DWP_IND_RLD_RST;
			ind_cnt_q    <= `DWP_IND_RLD_RST;
			ind_run_q    <= 1'b0;
			ind_rst_en_q <= 1'b1;
			strap_done_q <= 1'b0;
		end else begin
			// The option strap is caught after reset release.
			if (!strap_done_q) begin
				strap_done_q <= 1'b1;
				if (OPT_HW_START) begin
					ind_run_q <= 1'b1;
				end
			end
			if (WR && hit(ADDR, `DWP_OFF_IND_PRE)) begin
				pre_q        <= WDATA[2:0];
				ind_rst_en_q <= WDATA[8];
			end
			if (WR && hit(ADDR, `DWP_OFF_IND_RLD)) begin
				rld_q <= WDATA[11:0];
			end
			if (wr_key) begin
				key_q <= WDATA[15:0];
			end
			if (wr_key && (WDATA[15:0] == `DWP_KEY_START)) begin
				ind_run_q <= 1'b1;
				ind_cnt_q <= rld_q;
			end else if (sel_rld_ok) begin
				ind_cnt_q <= rld_q;
			end else if (ind_expire) begin
				ind_cnt_q <= rld_q;
			end else if (ind_tick) begin
				ind_cnt_q <= ind_cnt_q - 12'h001;
			end
		end
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			win_cnt_q    <= `DWP_WIN_CNT_RST;
			win_win_q    <= `DWP_WIN_WIN_RST;
			win_en_q     <= 1'b0;
			win_rst_en_q <= 1'b0;
		end else begin
			if (WR && hit(ADDR, `DWP_OFF_WIN_CFG)) begin
				win_win_q    <= WDATA[6:0];
				win_rst_en_q <= WDATA[8];
			end
			if (wr_win) begin
				win_cnt_q <= WDATA[6:0];
				if (WDATA[7]) begin
					win_en_q <= 1'b1;
				end
			end else if (win_tick) begin
				win_cnt_q <= win_cnt_q - 7'h01;
			end
		end
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stat_q        <= 3'h0;
			mask_q        <= 3'h0;
			dbg_q         <= 2'h0;
			SYS_RESET_REQ <= 1'b0;
			WAKEUP_REQ    <= 1'b0;
		end else begin
			if (WR && hit(ADDR, `DWP_OFF_INT_MASK)) begin
				mask_q <= WDATA[2:0];
			end
			if (WR && hit(ADDR, `DWP_OFF_DBG)) begin
				dbg_q <= WDATA[1:0];
			end
			// A new event wins over a write-one clear in the same cycle.
			if (WR && hit(ADDR, `DWP_OFF_INT_STAT)) begin
				stat_q <= (stat_q & ~WDATA[2:0]) | ev;
			end else begin
				stat_q <= stat_q | ev;
			end
			SYS_RESET_REQ <= (ind_expire && ind_rst_en_q) || (win_fail && win_rst_en_q);
			WAKEUP_REQ    <= ind_expire && ind_rst_en_q && LOW_POWER;
		end
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= 32'h00000000;
		end else if (RD) begin
			if (hit(ADDR, `DWP_OFF_IND_KEY)) begin
				RDATA <= {16'h0000, key_q};
			end else if (hit(ADDR, `DWP_OFF_IND_PRE)) begin
				RDATA <= {23'h000000, ind_rst_en_q, 4'h0, ind_run_q, pre_q};
			end else if (hit(ADDR, `DWP_OFF_IND_RLD)) begin
				RDATA <= {20'h00000, rld_q};
			end else if (hit(ADDR, `DWP_OFF_IND_CNT)) begin
				RDATA <= {20'h00000, ind_cnt_q};
			end else if (hit(ADDR, `DWP_OFF_WIN_CTRL)) begin
				RDATA <= {24'h000000, win_en_q, win_cnt_q};
			end else if (hit(ADDR, `DWP_OFF_WIN_CFG)) begin
				RDATA <= {23'h000000, win_rst_en_q, 1'b0, win_win_q};
			end else if (hit(ADDR, `DWP_OFF_INT_STAT)) begin
				RDATA <= {29'h00000000, stat_q};
			end else if (hit(ADDR, `DWP_OFF_INT_MASK)) begin
				RDATA <= {29'h00000000, mask_q};
			end else if (hit(ADDR, `DWP_OFF_DBG)) begin
				RDATA <= {30'h00000000, dbg_q};
			end else begin
				RDATA <= 32'h00000000;
			end
		end else begin
			RDATA <= 32'h00000000;
		end
	end
endmodule // dwp_top

// >>> logic/dwp_defines.vh
`ifndef DWP_DEFINES_VH
`define DWP_DEFINES_VH
`define DWP_OFF_IND_KEY    8'h00
`define DWP_OFF_IND_PRE    8'h04
`define DWP_OFF_IND_RLD    8'h08
`define DWP_OFF_IND_CNT    8'h0C
`define DWP_OFF_WIN_CTRL   8'h10
`define DWP_OFF_WIN_CFG    8'h14
`define DWP_OFF_INT_STAT   8'h18
`define DWP_OFF_INT_MASK   8'h1C
`define DWP_OFF_DBG        8'h20
`define DWP_KEY_START      16'hCCCC
`define DWP_KEY_RELOAD     16'hAAAA
`define DWP_IND_RLD_RST    12'hFFF
`define DWP_IND_PRE_RST    3'h0
`define DWP_WIN_CNT_RST    7'h7F
`define DWP_WIN_WIN_RST    7'h7F
`define DWP_WIN_EWI_VAL    7'h40
`define DWP_WIN_TRIG_BIT   6
`define DWP_WIN_DIV        4096
`define DWP_BIT_IND_EXP    0
`define DWP_BIT_WIN_EWI    1
`define DWP_BIT_WIN_RST    2
`define DWP_STAT_W         3
`endif

// >>> logic/dwp_sync3.v
`timescale 1ns/100ps
// Three-stage synchroniser; the output changes once stages two and three agree.
module dwp_sync3 (
	input  wire CLK,
	input  wire SYS_RST,
	input  wire d,
	output reg  q
);
	reg [2:0] s_q;

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_q <= 3'h0;
			q   <= 1'b0;
		end else begin
			s_q <= {s_q[1:0], d};
			if (s_q[1] == s_q[2]) begin
				q <= s_q[2];
			end
		end
	end
endmodule // dwp_sync3

// >>> logic/dwp_prescaler.v
`timescale 1ns/100ps
// Divides a one-cycle enable by 4 << sel, sel clamped to 6, giving seven factors from 4 to 256.
module dwp_prescaler (
	input  wire       CLK,
	input  wire       SYS_RST,
	input  wire       en,
	input  wire       clr,
	input  wire [2:0] sel,
	output wire       tick
);
	reg  [7:0] cnt_q;
	wire [2:0] s;
	wire [7:0] lim;

	assign s    = (sel > 3'h6) ? 3'h6 : sel;
	assign lim  = (8'h04 << s) - 8'h01;
	assign tick = en && (cnt_q == lim);

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cnt_q <= 8'h00;
		end else if (clr || tick) begin
			cnt_q <= 8'h00;
		end else if (en) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule // dwp_prescaler

// >>> testbench/dwp_checker.sv
`timescale 1ns/100ps
module dwp_checker #(
	parameter WIN_DIV = 4096
) (
	input wire        CLK,
	input wire        SYS_RST,
	input wire [7:0]  ADDR,
	input wire        WR,
	input wire        RD,
	input wire [31:0] RDATA,
	input wire        IRQ,
	input wire        SYS_RESET_REQ,
	input wire        WAKEUP_REQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	sequence rd_cnt;
		RD && ADDR == 8'h0C;
	endsequence
	sequence rd_pre;
		RD && ADDR == 8'h04;
	endsequence
	sequence rd_win;
		RD && ADDR == 8'h10;
	endsequence
	sequence rd_stat;
		RD && ADDR == 8'h18;
	endsequence
	AST_CNT_W: assert property (rd_cnt |=> RDATA[31:12] == 20'h0)
		else $error("count read too wide");
	AST_PRE_W: assert property (rd_pre |=> RDATA[31:9] == 23'h0)
		else $error("prescale read too wide");
	AST_WIN_W: assert property (rd_win |=> RDATA[31:8] == 24'h0)
		else $error("window read too wide");
	AST_STAT_W: assert property (rd_stat |=> RDATA[31:3] == 29'h0)
		else $error("status read too wide");
	AST_RD_IDLE: assert property (!RD |=> RDATA == 32'h0)
		else $error("read data outside read slot");
	AST_RST_PULSE: assert property (SYS_RESET_REQ |=> !SYS_RESET_REQ)
		else $error("reset request longer than one cycle");
	AST_WAKE: assert property (WAKEUP_REQ |-> SYS_RESET_REQ)
		else $error("wake request without reset request");
	AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(WR))
		else $error("interrupt dropped without a write");
endmodule // dwp_checker
bind dwp_top dwp_checker #(.WIN_DIV(WIN_DIV)) u_chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
	.IRQ(IRQ), .SYS_RESET_REQ(SYS_RESET_REQ), .WAKEUP_REQ(WAKEUP_REQ)
);

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0, rst = 1'b1, halt = 1'b0, lp = 1'b0, we = 1'b0, re = 1'b0, hw = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, v, c;
	wire  [31:0] rdata;
	wire         irq, rreq, wreq;
	int          fails = 0, comparisons = 0, cyc = 0, nr = 0;
	// The slow oscillator is a CLK/8 square wave, far faster than real to keep runs short.
	dwp_top #(.WIN_DIV(4)) dut (.CLK(clk), .SYS_RST(rst), .LOW_SPEED_INTERNAL_OSC(cyc[2]),
		.OPT_HW_START(hw), .CORE_HALTED(halt), .LOW_POWER(lp), .ADDR(addr),
		.WDATA(wdata), .WR(we), .RD(re), .RDATA(rdata), .IRQ(irq),
		.SYS_RESET_REQ(rreq), .WAKEUP_REQ(wreq));
	initial forever #20 clk = ~clk;
	task final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rreq === 1'b1) nr <= nr + 1;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 v = rdata;
		chk(v & m, e);
	endtask
	// Waits a bounded time for the interrupt (0) or the reset request (1).
	task wt(input bit w);
		bit h;
		h = 1'b0;
		for (int i = 0; i < 12000 && !h; i++) begin
			@(posedge clk);
			#1 h = w ? rreq : irq;
		end
		chk(h, 1);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(8'h08, 32'hFFF);
		rd(8'h04, 32'h100);
		rd(8'h0C, 32'hFFF);
		rd(8'h14, 32'h7F, 32'h7F);
		rd(8'h10, 32'h7F);
		rd(8'h3C, 32'h0);
		$display("reset values done");
		wr(8'h08, 32'h3);
		wr(8'h00, 32'hCCCC);
		rd(8'h04, 32'h108);
		wr(8'h1C, 32'h1);
		lp <= 1'b1;
		wt(1);
		chk(wreq, 1);
		chk(irq, 1);
		lp <= 1'b0;
		wr(8'h04, 32'h6);
		wr(8'h18, 32'h1);
		#1;
		chk(irq, 0);
		c = nr;
		wt(0);
		chk(nr, c);
		$display("independent watchdog done");
		wr(8'h18, 32'h1);
		wr(8'h20, 32'h3);
		wr(8'h04, 32'h0);
		halt <= 1'b1;
		rd(8'h0C, 32'h0, 32'h0);
		c = v;
		repeat (200) @(posedge clk);
		rd(8'h0C, c);
		wr(8'h08, 32'h5);
		wr(8'h00, 32'hAAAA);
		rd(8'h0C, 32'h5);
		rd(8'h00, 32'hAAAA);
		$display("freeze done");
		wr(8'h1C, 32'h6);
		wr(8'h14, 32'h17F);
		wr(8'h10, 32'hC1);
		repeat (100) @(posedge clk);
		rd(8'h18, 32'h0, 32'h6);
		halt <= 1'b0;
		wt(0);
		rd(8'h18, 32'h2, 32'h6);
		wt(1);
		chk(wreq, 0);
		rd(8'h18, 32'h6, 32'h6);
		$display("window watchdog done");
		@(posedge clk);
		hw <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h04, 32'h108);
		rd(8'h0C, 32'hFFF);
		$display("hardware start done");
		final_report;
	end
endmodule // tb
